// ==== rtl/sensor_two_wire_register_slave.sv ====
// Two-wire register slave: the device end of the serial link
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Clock line is input only, never pulled
// - Both lines high means bus idle
// - Only the master makes start and stop
// - Data falling with clock high is start
// - Repeated start begins a new transaction
// - Data rising with clock high is stop
// - Eight bits MSB first, then ack bit
// - Data changes only while clock low
// - First byte: address high seven, direction bit
// - Select low answers 0x20 and 0x21
// - Select high answers 0x30 and 0x31
// - Programmed alternate address overrides pin choice
// - Receiver pulls data low to acknowledge
// - Master nack ends read, device releases data
// - Acknowledge address only on exact match
// - Write header carries two register address bytes
// - Each write data byte stored and acknowledged
// - Random read: address write, restart, read
// - Master acks to request another byte
// - Register pointer increments after every data byte
// - Pointer high byte first, then low
// - Plain read starts at current pointer
// - Sequential writes go to incrementing addresses

module sensor_two_wire_register_slave
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic addr_sel,
  two_wire_if.dev bus,
  output logic [15:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic busy
);

  two_wire_pkg::dev_state_t state_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic [1:0] idx_reg;
  logic [15:0] ptr_reg;
  logic read_reg;
  logic more_reg;
  logic sda_oe_reg;
  logic alt_valid_reg;
  logic [6:0] alt_addr_reg;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic [6:0] own_addr;

  // ****************************************
  // Pin synchronisers and line events
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 3'h3;
      sync2_reg <= 3'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1_reg <= {addr_sel, bus.sda_line, bus.scl_line};
      sync2_reg <= sync1_reg;
      scl_prev_reg <= sync2_reg[0];
      sda_prev_reg <= sync2_reg[1];
    end
  end

  assign scl_s = sync2_reg[0];
  assign sda_s = sync2_reg[1];
  assign sel_s = sync2_reg[2];
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_seen = scl_s & scl_prev_reg & sda_prev_reg
    & ~sda_s;
  assign stop_seen = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign byte_done = scl_fall & (bit_cnt_reg == two_wire_pkg::BITS_PER_BYTE);

  // Alternate address overrides the strap choice once written
  always_comb
  begin
    if (alt_valid_reg)
      own_addr = alt_addr_reg;
    else if (sel_s)
      own_addr = two_wire_pkg::DEV_ADDR_HIGH;
    else
      own_addr = two_wire_pkg::DEV_ADDR_LOW;
  end

  // The clock line is never driven; data only pulls low
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_reg;
  assign rd_addr = ptr_reg;

  // ****************************************
  // Alternate bus address register
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alt_valid_reg <= 1'b0;
      alt_addr_reg <= two_wire_pkg::ALT_RESET;
    end
    else if (clk_en && wr_stb && wr_addr == two_wire_pkg::ALT_ADDR_REG)
    begin
      alt_valid_reg <= 1'b1;
      alt_addr_reg <= wr_data[7:1];
    end
  end

  // ****************************************
  // Protocol engine
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= two_wire_pkg::S_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      idx_reg <= 2'h0;
      ptr_reg <= two_wire_pkg::PTR_RESET;
      read_reg <= 1'b0;
      more_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_addr <= two_wire_pkg::PTR_RESET;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      busy <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_stb <= 1'b0;
      if (start_seen)
      begin
        state_reg <= two_wire_pkg::S_ADDR;
        bit_cnt_reg <= 4'h0;
        idx_reg <= 2'h0;
        sda_oe_reg <= 1'b0;
        busy <= 1'b1;
      end
      else if (stop_seen)
      begin
        state_reg <= two_wire_pkg::S_IDLE;
        sda_oe_reg <= 1'b0;
        busy <= 1'b0;
      end
      else
      begin
        case (state_reg)
          two_wire_pkg::S_ADDR, two_wire_pkg::S_RX:
          begin
            if (scl_rise)
            begin
              sh_reg <= {sh_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (byte_done && state_reg == two_wire_pkg::S_ADDR)
            begin
              read_reg <= sh_reg[0];
              if (sh_reg[7:1] == own_addr)
              begin
                sda_oe_reg <= 1'b1;
                state_reg <= two_wire_pkg::S_ADDR_ACK;
              end
              else
                state_reg <= two_wire_pkg::S_IGNORE;
            end
            else if (byte_done)
            begin
              sda_oe_reg <= 1'b1;
              state_reg <= two_wire_pkg::S_RX_ACK;
              case (idx_reg)
                2'h0: ptr_reg[15:8] <= sh_reg;
                2'h1: ptr_reg[7:0] <= sh_reg;
                default:
                begin
                  wr_addr <= ptr_reg;
                  wr_data <= sh_reg;
                  wr_stb <= 1'b1;
                  ptr_reg <= ptr_reg + 16'h0001;
                end
              endcase
              if (idx_reg != two_wire_pkg::IDX_DATA)
                idx_reg <= idx_reg + 2'h1;
            end
          end
          two_wire_pkg::S_ADDR_ACK:
            if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (read_reg)
              begin
                sh_reg <= rd_data;
                sda_oe_reg <= ~rd_data[7];
                state_reg <= two_wire_pkg::S_TX;
              end
              else
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= two_wire_pkg::S_RX;
              end
            end
          two_wire_pkg::S_RX_ACK:
            if (scl_fall)
            begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= two_wire_pkg::S_RX;
            end
          two_wire_pkg::S_TX:
            if (scl_rise)
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            else if (byte_done)
            begin
              sda_oe_reg <= 1'b0;
              ptr_reg <= ptr_reg + 16'h0001;
              state_reg <= two_wire_pkg::S_TX_ACK;
            end
            else if (scl_fall)
            begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_oe_reg <= ~sh_reg[6];
            end
          two_wire_pkg::S_TX_ACK:
            if (scl_rise)
              more_reg <= ~sda_s;
            else if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (more_reg)
              begin
                sh_reg <= rd_data;
                sda_oe_reg <= ~rd_data[7];
                state_reg <= two_wire_pkg::S_TX;
              end
              else
                state_reg <= two_wire_pkg::S_IGNORE;
            end
          two_wire_pkg::S_IGNORE:
            sda_oe_reg <= 1'b0;
          default:
            sda_oe_reg <= 1'b0;
        endcase
      end
    end
  end

endmodule // sensor_two_wire_register_slave

`default_nettype wire

// ==== rtl/two_wire_pkg.sv ====
// Shared constants and types for both ends of the two-wire register link
package two_wire_pkg;

  // ****************************************
  // Bus addresses
  // ****************************************
  localparam logic [6:0] DEV_ADDR_LOW = 7'h10;
  localparam logic [6:0] DEV_ADDR_HIGH = 7'h18;
  localparam logic [15:0] ALT_ADDR_REG = 16'h31FC;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [6:0] ALT_RESET = 7'h00;

  // ****************************************
  // Framing and timing
  // ****************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BITS_WITH_ACK = 4'h9;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_HALF_CYCLES =
    (SCL_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Host command codes
  // ****************************************
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ADDR_ACK = 3'h2,
    S_RX = 3'h3,
    S_RX_ACK = 3'h4,
    S_TX = 3'h5,
    S_TX_ACK = 3'h6,
    S_IGNORE = 3'h7
  } dev_state_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_START = 2'h1,
    M_BITS = 2'h2,
    M_STOP = 2'h3
  } host_state_t;

endpackage

// ==== rtl/two_wire_if.sv ====
// Two-wire link wiring with open-drain resolution of both lines
`timescale 1ns/10ps
`default_nettype none

interface two_wire_if;
  logic scl_line;
  logic sda_line;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // Pull-up wins unless an enabled driver pulls low
  assign scl_line = ~(host_scl_oe & ~host_scl_o);
  assign sda_line = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (
    input scl_line,
    input sda_line,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input scl_line,
    input sda_line,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

`default_nettype wire

// ==== rtl/two_wire_host.sv ====
// Two-wire bus master that issues start, byte and stop commands
`timescale 1ns/10ps
`default_nettype none

module two_wire_host
#(
  parameter int HALF_CYCLES = two_wire_pkg::SCL_HALF_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  two_wire_if.host bus,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);

  two_wire_pkg::host_state_t state_reg;
  logic [1:0] sda_sync_reg;
  logic [15:0] timer_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] tx_sh_reg;
  logic [8:0] rx_sh_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic tick;

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_reg;
  assign bus.host_sda_oe = sda_oe_reg;
  assign tick = (timer_reg == 16'h0000);

  // ****************************************
  // Line sampling and half-period timer
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sda_sync_reg <= 2'h3;
    else if (clk_en)
      sda_sync_reg <= {sda_sync_reg[0], bus.sda_line};
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      timer_reg <= 16'h0000;
    else if (clk_en)
    begin
      if (state_reg == two_wire_pkg::M_IDLE || tick)
        timer_reg <= 16'(HALF_CYCLES - 1);
      else
        timer_reg <= timer_reg - 16'h0001;
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= two_wire_pkg::M_IDLE;
      phase_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      tx_sh_reg <= 9'h1FF;
      rx_sh_reg <= 9'h000;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      case (state_reg)
        two_wire_pkg::M_IDLE:
          if (cmd_valid)
          begin
            cmd_ready <= 1'b0;
            phase_reg <= 2'h0;
            bit_cnt_reg <= 4'h0;
            case (cmd_op)
              two_wire_pkg::OP_START: state_reg <= two_wire_pkg::M_START;
              two_wire_pkg::OP_STOP: state_reg <= two_wire_pkg::M_STOP;
              two_wire_pkg::OP_WRITE:
              begin
                tx_sh_reg <= {cmd_data, 1'b1};
                state_reg <= two_wire_pkg::M_BITS;
              end
              default:
              begin
                tx_sh_reg <= {8'hFF, cmd_nack};
                state_reg <= two_wire_pkg::M_BITS;
              end
            endcase
          end
        // Release, raise clock, pull data low with clock high
        two_wire_pkg::M_START:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default:
              begin
                scl_oe_reg <= 1'b1;
                state_reg <= two_wire_pkg::M_IDLE;
                cmd_ready <= 1'b1;
              end
            endcase
          end
        two_wire_pkg::M_BITS:
          if (tick)
          begin
            case (phase_reg)
              2'h0:
              begin
                sda_oe_reg <= ~tx_sh_reg[8];
                phase_reg <= 2'h1;
              end
              2'h1:
              begin
                scl_oe_reg <= 1'b0;
                phase_reg <= 2'h2;
              end
              default:
              begin
                scl_oe_reg <= 1'b1;
                rx_sh_reg <= {rx_sh_reg[7:0], sda_sync_reg[1]};
                tx_sh_reg <= {tx_sh_reg[7:0], 1'b1};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                phase_reg <= 2'h0;
                if (bit_cnt_reg == two_wire_pkg::BITS_PER_BYTE)
                begin
                  rsp_valid <= 1'b1;
                  rsp_data <= rx_sh_reg[7:0];
                  rsp_ack <= ~sda_sync_reg[1];
                  state_reg <= two_wire_pkg::M_IDLE;
                  cmd_ready <= 1'b1;
                end
              end
            endcase
          end
        // Data low, clock high, data released with clock high
        default:
          if (tick)
          begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              default:
              begin
                sda_oe_reg <= 1'b0;
                state_reg <= two_wire_pkg::M_IDLE;
                cmd_ready <= 1'b1;
              end
            endcase
          end
      endcase
    end
  end

endmodule // two_wire_host

`default_nettype wire

// ==== verification/two_wire_link_assertions.sv ====
// Link-level checks on the shared two-wire bus
`timescale 1ns/10ps
`default_nettype none

module two_wire_link_assertions
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic scl_q, sda_q, hi, rise, start, stop, first, rw, ign, nk;
  logic [3:0] cnt;

  assign hi = scl_line & scl_q;
  assign rise = scl_line & ~scl_q;
  assign start = hi & sda_q & ~sda_line;
  assign stop = hi & ~sda_q & sda_line;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_line;
      sda_q <= sda_line;
    end
  end

  // Bit count, direction and refusal state of the current byte
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 4'h0;
      first <= 1'b1;
      rw <= 1'b0;
      ign <= 1'b0;
      nk <= 1'b0;
    end
    else if (start | stop)
    begin
      cnt <= 4'h0;
      first <= 1'b1;
      ign <= 1'b0;
      nk <= 1'b0;
    end
    else if (rise)
    begin
      cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      first <= first & (cnt != 4'h9);
      rw <= (first && cnt == 4'h7) ? sda_line : rw;
      ign <= (first && cnt == 4'h8) ? sda_line : ign;
      nk <= (!first && rw && cnt == 4'h8) ? sda_line : nk;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_dev_drive_low: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data high");
  a_addr_quiet: assert property (
    first && cnt inside {[0:7]} |-> !dev_sda_oe)
    else $error("device drove data before address ack");
  a_dev_change_low: assert property (
    $changed(dev_sda_oe) |-> !hi && !rise)
    else $error("device data changed while clock high");
  a_addr_released: assert property (
    hi && first && cnt inside {[1:8]} |-> !dev_sda_oe)
    else $error("device drove data in address byte");
  a_write_released: assert property (
    hi && !first && !rw && cnt inside {[1:8]} |-> !dev_sda_oe)
    else $error("device drove data in written byte");
  a_read_ack_free: assert property (
    hi && !first && rw && cnt == 4'h9 |-> !dev_sda_oe)
    else $error("device held data in master ack bit");
  a_write_acked: assert property (
    hi && !first && !rw && !ign && cnt == 4'h9 |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  a_ack_timely: assert property (
    $fell(scl_line) && !first && !rw && !ign && cnt == 4'h8
    |-> ##[2:6] dev_sda_oe)
    else $error("acknowledge drive late");
  a_mismatch_quiet: assert property (ign |-> !dev_sda_oe)
    else $error("device drove data after address mismatch");
  a_nack_release: assert property (nk |-> !dev_sda_oe)
    else $error("device drove data after master nack");
  a_stop_release: assert property (stop |=> !dev_sda_oe [*8])
    else $error("device drove data after stop");
endmodule // two_wire_link_assertions

`default_nettype wire

// ==== verification/sensor_two_wire_register_slave_tb.sv ====
// Self-checking bench joining host and register slave over the link
`timescale 1ns/10ps
`default_nettype none

module sensor_two_wire_register_slave_tb;
  logic mclk, reset_n, addr_sel, cmd_valid, cmd_nack;
  logic cmd_ready, rsp_valid, rsp_ack, wr_stb, busy;
  logic [1:0] cmd_op;
  logic [7:0] cmd_data, rsp_data, rd_data, wr_data;
  logic [15:0] rd_addr, wr_addr;
  logic [23:0] wq[$];
  int err_total, compares;

  two_wire_if bus_if();
  two_wire_host #(.HALF_CYCLES(8)) two_wire_host_i (.mclk(mclk),
    .reset_n(reset_n), .clk_en(1'b1), .bus(bus_if.host),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  sensor_two_wire_register_slave sensor_two_wire_register_slave_i (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .addr_sel(addr_sel),
    .bus(bus_if.dev), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_stb(wr_stb), .busy(busy));
  two_wire_link_assertions two_wire_link_assertions_i (.mclk(mclk),
    .reset_n(reset_n), .scl_line(bus_if.scl_line),
    .sda_line(bus_if.sda_line), .dev_sda_o(bus_if.dev_sda_o),
    .dev_sda_oe(bus_if.dev_sda_oe));

  // Register contents seen by reads
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  assign rd_data = mem(rd_addr);

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(negedge mclk) if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});

  // ****************************************
  // Compare and drive tasks
  // ****************************************
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 300)
      chk1(cmd_ready, 1'b1);
  endtask

  task automatic cmd(input logic [1:0] op, input logic [7:0] d,
    input logic nk);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    wait_ready;
    @(negedge mclk);
    cmd_valid = 1'b0;
    wait_ready;
  endtask

  task automatic sta;
    cmd(two_wire_pkg::OP_START, 8'h00, 1'b0);
  endtask

  task automatic sto;
    cmd(two_wire_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic wbyte(input logic [7:0] d, input logic ack);
    cmd(two_wire_pkg::OP_WRITE, d, 1'b0);
    chk1(rsp_valid, 1'b1);
    chk1(rsp_ack, ack);
  endtask

  task automatic rbyte(input logic nk, input logic [7:0] exp);
    cmd(two_wire_pkg::OP_READ, 8'hFF, nk);
    chk8(rsp_data, exp);
  endtask

  task automatic exp_wr(input logic [15:0] a, input logic [7:0] d);
    logic [23:0] r;
    r = (wq.size() > 0) ? wq.pop_front() : 24'hXXXXXX;
    chk16(r[23:8], a);
    chk8(r[7:0], d);
  endtask

  task automatic do_reset;
    reset_n = 1'b0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk16(rd_addr, two_wire_pkg::PTR_RESET);
    chk1(busy, 1'b0);
    chk1(cmd_ready, 1'b1);
    wq.delete();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write;
    sta;
    chk1(busy, 1'b1);
    wbyte(8'h20, 1'b1);
    wbyte(8'h12, 1'b1);
    wbyte(8'h34, 1'b1);
    wbyte(8'h5A, 1'b1);
    wbyte(8'hC3, 1'b1);
    sto;
    repeat (4) @(negedge mclk);
    chk1(busy, 1'b0);
    exp_wr(16'h1234, 8'h5A);
    exp_wr(16'h1235, 8'hC3);
    chk16(rd_addr, 16'h1236);
  endtask

  task automatic t_rand_read;
    sta;
    wbyte(8'h20, 1'b1);
    wbyte(8'h00, 1'b1);
    wbyte(8'h40, 1'b1);
    sta;
    wbyte(8'h21, 1'b1);
    rbyte(1'b0, mem(16'h0040));
    rbyte(1'b1, mem(16'h0041));
    sto;
    chk16(rd_addr, 16'h0042);
    chk16(16'(wq.size()), 16'h0000);
  endtask

  task automatic t_cur_read;
    sta;
    wbyte(8'h21, 1'b1);
    rbyte(1'b1, mem(16'h0042));
    sto;
  endtask

  task automatic t_mismatch;
    sta;
    wbyte(8'h30, 1'b0);
    sto;
    sta;
    wbyte(8'h31, 1'b0);
    rbyte(1'b1, 8'hFF);
    sto;
  endtask

  task automatic t_strap;
    addr_sel = 1'b1;
    sta;
    wbyte(8'h30, 1'b1);
    sto;
    sta;
    wbyte(8'h20, 1'b0);
    sto;
    addr_sel = 1'b0;
  endtask

  task automatic t_alt;
    sta;
    wbyte(8'h20, 1'b1);
    wbyte(8'h31, 1'b1);
    wbyte(8'hFC, 1'b1);
    wbyte(8'h50, 1'b1);
    sto;
    exp_wr(two_wire_pkg::ALT_ADDR_REG, 8'h50);
    sta;
    wbyte(8'h50, 1'b1);
    wbyte(8'h00, 1'b1);
    wbyte(8'h10, 1'b1);
    wbyte(8'hA5, 1'b1);
    sto;
    exp_wr(16'h0010, 8'hA5);
    sta;
    wbyte(8'h51, 1'b1);
    rbyte(1'b1, mem(16'h0011));
    sto;
    sta;
    wbyte(8'h20, 1'b0);
    sto;
  endtask

  task automatic t_alt_cleared;
    sta;
    wbyte(8'h20, 1'b1);
    sto;
  endtask

  task automatic finish_test;
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    err_total++;
    finish_test;
  end

  initial
  begin
    reset_n = 1'b0;
    addr_sel = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = two_wire_pkg::OP_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    err_total = 0;
    compares = 0;
    do_reset;
    t_write;
    t_rand_read;
    t_cur_read;
    t_mismatch;
    t_strap;
    t_alt;
    do_reset;
    t_alt_cleared;
    finish_test;
  end
endmodule // sensor_two_wire_register_slave_tb

`default_nettype wire
